// File: core_model.sv
// processor core model: register-bus master and watchdog vector entry
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic        clock,
   output logic             awvalid,
   output logic [7:0]       awaddr,
   input  wire logic        awready,
   output logic             wvalid,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   input  wire logic        wready,
   input  wire logic        bvalid,
   input  wire logic [1:0]  bresp,
   output logic             bready,
   output logic             arvalid,
   output logic [7:0]       araddr,
   input  wire logic        arready,
   input  wire logic        rvalid,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   output logic             rready,
   output logic             wdVectorTaken
);
   initial begin
      {awvalid, wvalid, arvalid, wdVectorTaken} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {bready, rready} = 2'h3;
   end

   task automatic busWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      r = 2'h3;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'h1;
      for (int n = 0; n < 100; n++) begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
   endtask

   task automatic busRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      r = 2'h3;
      v = '0;
      arvalid <= 1'b1;
      araddr <= a;
      for (int n = 0; n < 100; n++) begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            r = rresp;
            break;
         end
      end
   endtask

   task automatic vectorEntry();
      wdVectorTaken <= 1'b1;
      @(posedge clock);
      wdVectorTaken <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: reset_watchdog_control.sv
// reset merging, start-up stretching and watchdog timer with an AXI4-Lite register slave
// What this block does
// - reset loads peripherals, then restart at vector
// - port reset acts at once without clock
// - fuse-selected delay stretches reset after sources
// - four causes: power, pin, watchdog, brown-out
// - low supply resets immediately, recovery starts delay
// - low reset pin resets clocklessly, rise starts delay
// - reset-disable fuse ignores the reset pin
// - enabled brown-out resets at once, delays release
// - watchdog reset is one-cycle pulse, delay after
// - bandgap on for brown-out, comparator or converter
// - watchdog counts slow ticks divided from the main clock
// - restart before timeout, else interrupt or reset
// - interrupt, reset, and interrupt-then-reset modes
// - watchdog interrupt wakes from any sleep
// - timeout selectable about 16 ms to 8 s
// - always-on fuse forces reset mode, locks bits
// - prescaler and reset-enable clear accepted only within four cycles
// - untimed clears or prescaler changes are refused
// - watchdog stays enabled across its own reset
// - reset-enable reads one while watchdog flag set
// - change-enable self-clears four cycles after set
// - prescaler code picks 2048 to 1048576 ticks
// - vector entry clears interrupt enable and flag
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_control #(
   parameter int STARTUP_BASE = reset_watchdog_pkg::STARTUP_BASE_CYC,
   parameter int WD_BASE      = reset_watchdog_pkg::WD_BASE_CYC,
   parameter int TICK_DIV     = reset_watchdog_pkg::TICK_CYC
) (
   input  wire logic                       clock,
   input  wire logic                       rst_b,
   input  wire reset_watchdog_pkg::fuse_s   fuses,
   input  wire reset_watchdog_pkg::analog_s analog,
   input  wire logic                       extResetPin_b,
   input  wire logic                       wdVectorTaken,
   input  wire logic                       awvalid,
   input  wire logic [7:0]                 awaddr,
   output logic                            awready,
   input  wire logic                       wvalid,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   output logic                            wready,
   output logic                            bvalid,
   output logic [1:0]                      bresp,
   input  wire logic                       bready,
   input  wire logic                       arvalid,
   input  wire logic [7:0]                 araddr,
   output logic                            arready,
   output logic                            rvalid,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   input  wire logic                       rready,
   output logic                            systemReset_b,
   output logic                            resetVectorStart,
   output logic                            wdResetPulse,
   output logic                            wdIrqWake,
   output logic                            bandgapEnable
);
   import reset_watchdog_pkg::*;

   logic        srcActive_b;
   logic        porRst_b;
   logic        srcMeta_reg;
   logic        srcSync_reg;
   rst_state_e  state_reg;
   logic [15:0] stretchCnt_reg;
   logic        systemReset_b_reg;
   logic        startPulse_reg;
   logic        wdPulse_reg;
   logic [10:0] tickCnt_reg;
   logic        wdTick_reg;
   logic [19:0] wdCnt_reg;
   logic        wdIrqFlag_reg;
   logic        wdIrqEn_reg;
   logic        wdResetEn_reg;
   logic        wdChange_reg;
   logic [2:0]  wdChangeCnt_reg;
   logic [3:0]  wdPrescale_reg;
   logic [3:0]  causeFlags_reg;
   logic        bandgap_reg;
   logic        wdIrq_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic [7:0]  wrAddr_reg;
   logic [31:0] wrData_reg;
   logic [3:0]  wrStrb_reg;
   logic        wrFire;
   logic        ctrlWrite;
   logic        causeWrite;
   logic        restart;
   logic        openSeq;
   logic        commitSeq;
   logic        wdeEff;
   logic        wdieEff;
   logic        wdRunning;
   logic        timeoutEvt;
   logic        wdFlagSet;
   logic        wdFire;
   logic [7:0]  ctrlView;
   logic [31:0] readWord;
   logic        readOk;
   logic [7:0]  d;

   function automatic logic [15:0] delayCycles(input fuse_s f);
      logic [2:0] sh;
      sh = {1'b0, f.startupTime} + {2'b00, f.clockSource[0]};
      return 16'(STARTUP_BASE) << sh;
   endfunction

   function automatic logic [19:0] wdLimit(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > WD_MAX_SEL) ? WD_MAX_SEL : sel;
      return 20'((21'(WD_BASE) << s) - 21'h1);
   endfunction

   // pin acts unclocked unless fused off
   assign srcActive_b = rst_b & ~analog.powerLow & (extResetPin_b | fuses.extResetDisable)
                        & ~(fuses.brownoutEnable & analog.brownoutLow);
   // watchdog set-up cleared only by port reset or low supply
   assign porRst_b = rst_b & ~analog.powerLow;

   // synchronous release of the merged source
   always_ff @(posedge clock or negedge srcActive_b) begin
      if (!srcActive_b) begin
         srcMeta_reg <= 1'b0;
         srcSync_reg <= 1'b0;
      end else begin
         srcMeta_reg <= 1'b1;
         srcSync_reg <= srcMeta_reg;
      end
   end

   // reset output drops asynchronously with the merged source, on a clock edge for the watchdog
   always_ff @(posedge clock or negedge srcActive_b) begin
      if (!srcActive_b) begin
         state_reg         <= HOLD;
         stretchCnt_reg    <= 16'h0;
         systemReset_b_reg <= 1'b0;
         startPulse_reg    <= 1'b0;
      end else begin
         startPulse_reg <= 1'b0;
         unique case (state_reg)
            HOLD: begin
               if (srcSync_reg && !wdPulse_reg) begin
                  stretchCnt_reg <= delayCycles(fuses);
                  state_reg      <= STRETCH;
               end
            end
            STRETCH: begin
               if (stretchCnt_reg <= 16'h1) begin
                  state_reg         <= RUN;
                  systemReset_b_reg <= 1'b1;
                  startPulse_reg    <= 1'b1;
               end else begin
                  stretchCnt_reg <= stretchCnt_reg - 16'h1;
               end
            end
            RUN: begin
               if (wdFire) begin
                  state_reg         <= HOLD;
                  systemReset_b_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         wdPulse_reg <= 1'b0;
      end else begin
         wdPulse_reg <= wdFire;
      end
   end

   // slow oscillator tick from the main clock
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         tickCnt_reg <= 11'h0;
         wdTick_reg  <= 1'b0;
      end else if (tickCnt_reg == 11'(TICK_DIV - 1)) begin
         tickCnt_reg <= 11'h0;
         wdTick_reg  <= 1'b1;
      end else begin
         tickCnt_reg <= tickCnt_reg + 11'h1;
         wdTick_reg  <= 1'b0;
      end
   end

   assign wdeEff    = wdResetEn_reg | causeFlags_reg[CAUSE_WD] | fuses.watchdogAlwaysOn;
   assign wdieEff   = wdIrqEn_reg & ~fuses.watchdogAlwaysOn;
   assign wdRunning = wdeEff | wdieEff;
   assign timeoutEvt = wdTick_reg & wdRunning & (wdCnt_reg == wdLimit(wdPrescale_reg));
   // interrupt first, reset if flag still pending
   assign wdFlagSet = timeoutEvt & wdieEff;
   assign wdFire    = timeoutEvt & wdeEff & (~wdieEff | wdIrqFlag_reg) & systemReset_b_reg;

   // restart or timeout clears the count
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         wdCnt_reg <= 20'h0;
      end else if (!systemReset_b_reg || restart || !wdRunning || timeoutEvt) begin
         wdCnt_reg <= 20'h0;
      end else if (wdTick_reg) begin
         wdCnt_reg <= wdCnt_reg + 20'h1;
      end
   end

   assign d          = wrData_reg[7:0];
   assign wrFire     = !awready_reg && !wready_reg && !bvalid_reg;
   assign ctrlWrite  = wrFire && (wrAddr_reg == OFF_WD_CTRL) && wrStrb_reg[0];
   assign causeWrite = wrFire && (wrAddr_reg == OFF_CAUSE) && wrStrb_reg[0];
   assign restart    = wrFire && (wrAddr_reg == OFF_RESTART);
   // opening write carries change and reset enable
   assign openSeq    = ctrlWrite && d[WD_CE_BIT] && d[WD_RE_BIT];
   // second write inside the open window
   assign commitSeq  = ctrlWrite && wdChange_reg && !d[WD_CE_BIT];

   // change window closes four cycles after opening
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         wdChange_reg    <= 1'b0;
         wdChangeCnt_reg <= 3'h0;
      end else if (openSeq) begin
         wdChange_reg    <= 1'b1;
         wdChangeCnt_reg <= 3'(WD_CHANGE_CYC - 1);
      end else if (commitSeq || (wdChange_reg && wdChangeCnt_reg == 3'h0)) begin
         wdChange_reg <= 1'b0;
      end else if (wdChange_reg) begin
         wdChangeCnt_reg <= wdChangeCnt_reg - 3'h1;
      end
   end

   // clearing and prescaler change only by commit
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         wdResetEn_reg  <= 1'b0;
         wdPrescale_reg <= 4'h0;
      end else if (ctrlWrite) begin
         if (d[WD_RE_BIT]) begin
            wdResetEn_reg <= 1'b1;
         end else if (commitSeq && !causeFlags_reg[CAUSE_WD]) begin
            wdResetEn_reg <= 1'b0;
         end
         if (commitSeq) begin
            wdPrescale_reg <= {d[WD_P3_BIT], d[2:0]};
         end
      end
   end

   // vector entry clears interrupt enable, so reset mode remains only if enabled; a flag set wins over any clear
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         wdIrqEn_reg   <= 1'b0;
         wdIrqFlag_reg <= 1'b0;
      end else begin
         if (ctrlWrite) begin
            wdIrqEn_reg <= d[WD_IE_BIT];
         end else if (wdVectorTaken) begin
            wdIrqEn_reg <= 1'b0;
         end
         if (wdFlagSet) begin
            wdIrqFlag_reg <= 1'b1;
         end else if ((ctrlWrite && d[WD_IF_BIT]) || wdVectorTaken) begin
            wdIrqFlag_reg <= 1'b0;
         end
      end
   end

   // cause flags: written zero clears, a new cause wins
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         causeFlags_reg <= CAUSE_RESET;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (causeWrite && !d[i]) begin
               causeFlags_reg[i] <= 1'b0;
            end
         end
         if (!extResetPin_b && !fuses.extResetDisable) begin
            causeFlags_reg[CAUSE_EXT] <= 1'b1;
         end
         if (fuses.brownoutEnable && analog.brownoutLow) begin
            causeFlags_reg[CAUSE_BO] <= 1'b1;
         end
         if (wdFire) begin
            causeFlags_reg[CAUSE_WD] <= 1'b1;
         end
      end
   end

   // bandgap request and wake-capable interrupt level
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         bandgap_reg <= 1'b0;
         wdIrq_reg   <= 1'b0;
      end else begin
         bandgap_reg <= fuses.brownoutEnable | analog.comparatorBandgapSelect
                        | analog.converterEnable;
         wdIrq_reg   <= wdIrqFlag_reg & wdieEff;
      end
   end

   assign ctrlView = {wdIrqFlag_reg, wdieEff, wdPrescale_reg[3], wdChange_reg,
                      wdeEff, wdPrescale_reg[2:0]};

   always_comb begin
      readOk   = 1'b1;
      readWord = 32'h0;
      unique case (araddr)
         OFF_WD_CTRL: readWord = {24'h0, ctrlView};
         OFF_CAUSE:   readWord = {28'h0, causeFlags_reg};
         OFF_RESTART: readWord = 32'h0;
         OFF_STATUS:  readWord = {29'h0, bandgap_reg, wdRunning, systemReset_b_reg};
         default:     readOk   = 1'b0;
      endcase
   end

   // write channels taken in either order, response after both
   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         wrAddr_reg  <= 8'h0;
         wrData_reg  <= 32'h0;
         wrStrb_reg  <= 4'h0;
      end else begin
         if (awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            wrAddr_reg  <= awaddr;
         end
         if (wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wrData_reg <= wdata;
            wrStrb_reg <= wstrb;
         end
         if (wrFire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wrAddr_reg > OFF_STATUS || wrAddr_reg[1:0] != 2'h0)
                          ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_reg && bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge porRst_b) begin
      if (!porRst_b) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= RESP_OKAY;
      end else if (arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= readWord;
         rresp_reg   <= readOk ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   assign awready          = awready_reg;
   assign wready           = wready_reg;
   assign bvalid           = bvalid_reg;
   assign bresp            = bresp_reg;
   assign arready          = arready_reg;
   assign rvalid           = rvalid_reg;
   assign rdata            = rdata_reg;
   assign rresp            = rresp_reg;
   assign systemReset_b    = systemReset_b_reg;
   assign resetVectorStart = startPulse_reg;
   assign wdResetPulse     = wdPulse_reg;
   assign wdIrqWake        = wdIrq_reg;
   assign bandgapEnable    = bandgap_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!srcActive_b);

   chk_change_window: assert property ($rose(wdChange_reg) |-> ##4 !wdChange_reg)
      else $error("change window not closed after four cycles");
   chk_locked_prescale: assert property (ctrlWrite && !wdChange_reg |=> $stable(wdPrescale_reg))
      else $error("prescaler changed outside the timed window");
   chk_wde_sticky: assert property (causeFlags_reg[CAUSE_WD] && wdResetEn_reg |=> wdResetEn_reg)
      else $error("reset enable cleared while watchdog flag set");
   chk_always_on: assert property (fuses.watchdogAlwaysOn && timeoutEvt && systemReset_b_reg |=> wdPulse_reg && !wdIrqFlag_reg)
      else $error("always-on fuse did not force a reset");
   chk_pulse_single: assert property (wdPulse_reg |=> !wdPulse_reg && !systemReset_b_reg)
      else $error("watchdog pulse not one cycle or reset released");
   chk_stretch_load: assert property (state_reg == HOLD && srcSync_reg && !wdPulse_reg |=> stretchCnt_reg == delayCycles(fuses))
      else $error("delay counter loaded with wrong length");
   chk_stretch_end: assert property (state_reg == STRETCH && stretchCnt_reg == 16'h2 |=> !systemReset_b_reg ##1 systemReset_b_reg && startPulse_reg)
      else $error("reset not released at end of stretch");
   chk_source_holds: assert property (disable iff (!rst_b) !srcSync_reg |-> !systemReset_b_reg)
      else $error("reset released while a source is active");
   chk_irq_mode: assert property (timeoutEvt && wdieEff |=> wdIrqFlag_reg)
      else $error("interrupt flag not set on timeout");
   chk_combined_reset: assert property (timeoutEvt && wdeEff && wdieEff && wdIrqFlag_reg && systemReset_b_reg |=> wdPulse_reg)
      else $error("second timeout without service did not reset");
   chk_vector_clear: assert property (wdVectorTaken && !ctrlWrite && !wdFlagSet |=> !wdIrqFlag_reg && !wdIrqEn_reg)
      else $error("vector entry did not clear enable and flag");

   cov_irq_timeout: cover property (timeoutEvt && wdieEff);
   cov_wd_reset: cover property (wdPulse_reg ##1 !wdPulse_reg);
   cov_commit: cover property (openSeq ##[1:4] commitSeq);
   cov_release: cover property ($rose(systemReset_b_reg));
endmodule
`default_nettype wire

// File: reset_watchdog_pkg.sv
// constants, field layout and carriers for the reset and watchdog controller
package reset_watchdog_pkg;
   localparam int CLK_HZ            = 200_000_000;
   localparam int WDOSC_HZ          = 128_000;
   localparam int TICK_CYC          = CLK_HZ / WDOSC_HZ;
   localparam int STARTUP_BASE_US   = 4;
   localparam int STARTUP_BASE_CYC  = (STARTUP_BASE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int WD_CHANGE_CYC     = 4;
   localparam int WD_BASE_CYC       = 2048;
   localparam logic [3:0] WD_MAX_SEL = 4'h9;

   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_WD_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CAUSE   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RESTART = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0c;

   localparam int WD_IF_BIT = 7;
   localparam int WD_IE_BIT = 6;
   localparam int WD_P3_BIT = 5;
   localparam int WD_CE_BIT = 4;
   localparam int WD_RE_BIT = 3;
   localparam int CAUSE_WD  = 3;
   localparam int CAUSE_BO  = 2;
   localparam int CAUSE_EXT = 1;
   localparam int CAUSE_POR = 0;
   localparam logic [3:0] CAUSE_RESET = 4'h1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] startupTime;
      logic [3:0] clockSource;
      logic       extResetDisable;
      logic       watchdogAlwaysOn;
      logic       brownoutEnable;
   } fuse_s;

   typedef struct packed {
      logic powerLow;
      logic brownoutLow;
      logic comparatorBandgapSelect;
      logic converterEnable;
   } analog_s;

   typedef enum logic [1:0] {HOLD, STRETCH, RUN} rst_state_e;
endpackage

// File: reset_watchdog_top_note_placeholder_unused.sv
// intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: test_reset_and_watchdog_control.sv
// self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_watchdog_control;
   import reset_watchdog_pkg::*;
   localparam int SB = 4;
   logic        clock, rst_b, extResetPin_b, wdVectorTaken;
   fuse_s       fuses;
   analog_s     analog;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        systemReset_b, resetVectorStart, wdResetPulse, wdIrqWake, bandgapEnable;
   int          failures = 0;
   int          n_checks = 0;

   reset_watchdog_control #(.STARTUP_BASE(SB), .WD_BASE(64), .TICK_DIV(3)) u_dut (
      .clock, .rst_b, .fuses, .analog, .extResetPin_b, .wdVectorTaken,
      .awvalid, .awaddr, .awready, .wvalid, .wdata, .wstrb, .wready, .bvalid, .bresp,
      .bready, .arvalid, .araddr, .arready, .rvalid, .rdata, .rresp, .rready,
      .systemReset_b, .resetVectorStart, .wdResetPulse, .wdIrqWake, .bandgapEnable);
   core_model u_core (
      .clock, .awvalid, .awaddr, .awready, .wvalid, .wdata, .wstrb, .wready, .bvalid,
      .bresp, .bready, .arvalid, .araddr, .arready, .rvalid, .rdata, .rresp, .rready,
      .wdVectorTaken);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic fail(input string nm);
      failures++;
      $display("ERROR %s expected completion seen timeout", nm);
      wrap_up();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
      logic [1:0] r;
      u_core.busWrite(a, v, r);
      if (r === 2'h3) fail("bresp");
      check("bresp", 32'(r), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff, input logic [1:0] er = 2'h0);
      logic [1:0] r;
      u_core.busRead(a, d, r);
      if (r === 2'h3) fail("rresp");
      check("rresp", 32'(r), 32'(er));
      check("rdata", d & m, e);
   endtask

   task automatic waitRun();
      int n;
      for (n = 0; n < 300 && systemReset_b !== 1'b1; n++) @(posedge clock);
      if (n == 300) fail("run");
      check("stretch", 32'(n >= (SB << 1)), 32'h1);
   endtask

   task automatic waitIrq(input int lo, input int hi);
      int n;
      for (n = 0; n < 1000 && wdIrqWake !== 1'b1; n++) @(posedge clock);
      if (n == 1000) fail("irq");
      check("irqTime", 32'(n >= lo && n <= hi), 32'h1);
   endtask

   task automatic t_reset();
      check("rstHeld", 32'(systemReset_b), 32'h0);
      waitRun();
      check("vector", 32'(resetVectorStart), 32'h1);
      rd(OFF_CAUSE, 32'(CAUSE_RESET));
      rd(OFF_WD_CTRL, 32'h0);
      rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(8'h20, 32'h1, RESP_SLVERR);
   endtask

   task automatic t_bandgap();
      for (int i = 0; i < 9; i++) begin
         fuses.brownoutEnable <= i[0];
         analog.comparatorBandgapSelect <= i[1];
         analog.converterEnable <= i[2];
         repeat (3) @(posedge clock);
         check("bandgap", 32'(bandgapEnable), 32'(|i[2:0]));
      end
   endtask

   task automatic t_pins();
      extResetPin_b <= 1'b0;
      // no clock edge between the pin falling and the look
      #1 check("extRst", 32'(systemReset_b), 32'h0);
      repeat (4) @(posedge clock);
      extResetPin_b <= 1'b1;
      waitRun();
      analog.brownoutLow <= 1'b1;
      fuses.brownoutEnable <= 1'b1;
      #1 check("boRst", 32'(systemReset_b), 32'h0);
      repeat (4) @(posedge clock);
      analog.brownoutLow <= 1'b0;
      waitRun();
      rd(OFF_CAUSE, 32'h7);
      wr(OFF_CAUSE, 32'h0);
      fuses.extResetDisable <= 1'b1;
      fuses.brownoutEnable <= 1'b0;
      extResetPin_b <= 1'b0;
      analog.brownoutLow <= 1'b1;
      repeat (5) @(posedge clock);
      check("ignored", 32'(systemReset_b), 32'h1);
      extResetPin_b <= 1'b1;
      analog.brownoutLow <= 1'b0;
      fuses.extResetDisable <= 1'b0;
      rd(OFF_CAUSE, 32'h0);
   endtask

   task automatic t_timed();
      wr(OFF_RESTART, 32'h0);
      wr(OFF_WD_CTRL, 32'h08);
      wr(OFF_WD_CTRL, 32'h01);
      rd(OFF_WD_CTRL, 32'h08);
      wr(OFF_WD_CTRL, 32'h18);
      repeat (8) @(posedge clock);
      rd(OFF_WD_CTRL, 32'h08);
      wr(OFF_WD_CTRL, 32'h00);
      rd(OFF_WD_CTRL, 32'h08);
      wr(OFF_WD_CTRL, 32'h18);
      wr(OFF_WD_CTRL, 32'h00);
      rd(OFF_WD_CTRL, 32'h00);
   endtask

   task automatic t_irq();
      wr(OFF_WD_CTRL, 32'h40);
      wr(OFF_RESTART, 32'h0);
      waitIrq(182, 204);
      u_core.vectorEntry();
      repeat (2) @(posedge clock);
      check("irqClr", 32'(wdIrqWake), 32'h0);
      rd(OFF_WD_CTRL, 32'h00);
      wr(OFF_RESTART, 32'h0);
      wr(OFF_WD_CTRL, 32'h18);
      wr(OFF_WD_CTRL, 32'h41);
      rd(OFF_WD_CTRL, 32'h41);
      wr(OFF_RESTART, 32'h0);
      waitIrq(376, 400);
      u_core.vectorEntry();
   endtask

   task automatic t_wdreset();
      int w;
      wr(OFF_WD_CTRL, 32'h48);
      wr(OFF_RESTART, 32'h0);
      waitIrq(376, 400);
      check("irqFirst", 32'(systemReset_b), 32'h1);
      for (w = 0; w < 500 && wdResetPulse !== 1'b1; w++) @(posedge clock);
      if (w == 500) fail("wdPulse");
      for (w = 0; w < 4 && wdResetPulse === 1'b1; w++) @(posedge clock);
      check("pulseLen", 32'(w), 32'h1);
      check("wdRst", 32'(systemReset_b), 32'h0);
      waitRun();
      rd(OFF_CAUSE, 32'h8);
      rd(OFF_WD_CTRL, 32'h08, 32'h08);
      wr(OFF_WD_CTRL, 32'h18);
      wr(OFF_WD_CTRL, 32'h00);
      rd(OFF_WD_CTRL, 32'h08, 32'h08);
      wr(OFF_CAUSE, 32'h0);
      wr(OFF_WD_CTRL, 32'h18);
      wr(OFF_WD_CTRL, 32'h80);
      rd(OFF_WD_CTRL, 32'h00);
   endtask

   task automatic t_always();
      fuses.watchdogAlwaysOn <= 1'b1;
      wr(OFF_RESTART, 32'h0);
      wr(OFF_WD_CTRL, 32'h40);
      rd(OFF_WD_CTRL, 32'h08, 32'h48);
      wr(OFF_WD_CTRL, 32'h18);
      wr(OFF_WD_CTRL, 32'h00);
      rd(OFF_WD_CTRL, 32'h08, 32'h08);
   endtask

   // supply drop in mid-run: immediate reset, registers back to initial values
   task automatic t_power();
      analog.powerLow <= 1'b1;
      #1 check("porRst", 32'(systemReset_b), 32'h0);
      repeat (3) @(posedge clock);
      analog.powerLow <= 1'b0;
      waitRun();
      rd(OFF_CAUSE, 32'(CAUSE_RESET));
      rd(OFF_STATUS, 32'h3);
   endtask

   initial begin
      rst_b = 1'b0;
      extResetPin_b = 1'b1;
      fuses = '0;
      fuses.startupTime = 2'h1;
      analog = '0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      t_reset();
      t_bandgap();
      t_pins();
      t_timed();
      t_irq();
      t_wdreset();
      t_always();
      t_power();
      wrap_up();
   end
endmodule
`default_nettype wire
